// File: cpms_pkg.sv
package cpms_pkg;
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int TRIM_SHORT_US = 100;
    localparam int TRIM_LONG_US = 1000;
    localparam int TRIM_RUN_US = 500;
    localparam int TRIM_SHORT_CYC = TRIM_SHORT_US * CLK_MHZ;
    localparam int TRIM_LONG_CYC = TRIM_LONG_US * CLK_MHZ;
    localparam int TRIM_RUN_CYC = TRIM_RUN_US * CLK_MHZ;
    localparam int SETTLE_CYC = 8;
    localparam int CNT_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_SPAN_I = 4'h3;
    localparam logic [3:0] IDX_SPAN_Q = 4'hB;

    // Control register fields
    localparam int CTRL_TRIM_BIT = 15;
    localparam int CTRL_PHASE_BIT = 14;
    localparam int CTRL_TEST_BIT = 12;
    localparam int CTRL_PDI_BIT = 11;
    localparam int CTRL_PDQ_BIT = 10;

    // Status register fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_ECM_BIT = 1;
    localparam int STAT_INHIBIT_BIT = 2;

    // Reset values and span codes
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] SPAN_LOW_CODE = 16'h0000;
    localparam logic [15:0] SPAN_HIGH_CODE = 16'h4000;
    localparam logic [15:0] SPAN_RESET = SPAN_HIGH_CODE;

    // Serial frame: read flag, index, data
    localparam int FRAME_BITS = 24;
    localparam int FRAME_RD_BIT = 23;
    localparam int FRAME_IDX_LSB = 16;
    localparam logic [4:0] FRAME_LAST = 5'h17;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic trimDelaySelect;
        logic trimRequest;
        logic powerDownI;
        logic powerDownQ;
        logic testPatternSelect;
        logic unsplitOutputSelect;
        logic inputSpanSelect;
        logic outputPhaseSelect;
        logic extendedControlEnableN;
        logic serialSelectN;
    } cpms_pins_t;

    localparam int PIN_W = $bits(cpms_pins_t);
    localparam logic [9:0] PINS_IDLE = 10'h003;

    typedef struct packed {
        logic powerDownI;
        logic powerDownQ;
        logic testPatternOn;
        logic unsplitOutput;
        logic outputPhase90;
        logic extendedControlMode;
        logic [15:0] spanI;
        logic [15:0] spanQ;
    } cpms_setting_t;

    typedef enum logic [3:0] {
        ST_SETTLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_IDLE = 4'b0100,
        ST_RUN = 4'b1000
    } cpms_trim_state_t;
endpackage : cpms_pkg

// File: cpms_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpms_top #(
    parameter int unsigned TRIM_LONG_CYCLES = cpms_pkg::TRIM_LONG_CYC,
    parameter int unsigned TRIM_RUN_CYCLES = cpms_pkg::TRIM_RUN_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire cpms_pkg::cpms_pins_t ctrlPins,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic selfTrimRunning,
    output var cpms_pkg::cpms_setting_t settings,
    output logic serialOut,
    output logic serialOutEn
);
    import cpms_pkg::*;

    function automatic logic [15:0] mergeBytes(input logic [15:0] oldV,
                                               input logic [15:0] newV,
                                               input logic [1:0] strb);
        logic [15:0] r;
        r = oldV;
        if (strb[0]) begin
            r[7:0] = newV[7:0];
        end
        if (strb[1]) begin
            r[15:8] = newV[15:8];
        end
        return r;
    endfunction : mergeBytes

    function automatic logic isIdx(input logic [7:0] addr, input logic [3:0] idx);
        return addr[7:2] == {2'b00, idx};
    endfunction : isIdx

    // Pin synchroniser: a change counts once stages two and three agree
    logic [PIN_W-1:0] pinS1_q;
    logic [PIN_W-1:0] pinS2_q;
    logic [PIN_W-1:0] pinS3_q;
    logic [PIN_W-1:0] pinFilt_q;
    logic [PIN_W-1:0] pinAgree;
    cpms_pins_t pinF;
    logic extended_control_mode;

    assign pinAgree = ~(pinS2_q ^ pinS3_q);
    assign pinF = pinFilt_q;
    assign extended_control_mode = ~pinF.extendedControlEnableN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1_q <= PINS_IDLE;
            pinS2_q <= PINS_IDLE;
            pinS3_q <= PINS_IDLE;
            pinFilt_q <= PINS_IDLE;
        end else begin
            pinS1_q <= ctrlPins;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            pinFilt_q <= (pinS3_q & pinAgree) | (pinFilt_q & ~pinAgree);
        end
    end

    // Serial side; select high ends the frame and clears the shifter
    logic selRawN;
    logic [FRAME_BITS-1:0] shift_q;
    logic [4:0] bitCnt_q;
    logic [FRAME_BITS-1:0] frameWord_q;
    logic frameTgl_q;
    logic serialOut_q;

    assign selRawN = ctrlPins.serialSelectN;

    always_ff @(posedge serialClk or posedge selRawN) begin
        if (selRawN) begin
            shift_q <= '0;
            bitCnt_q <= '0;
            serialOut_q <= 1'b0;
        end else begin
            shift_q <= {shift_q[FRAME_BITS-2:0], serialIn};
            bitCnt_q <= (bitCnt_q == FRAME_LAST) ? 5'h00 : bitCnt_q + 5'h01;
            serialOut_q <= shift_q[FRAME_BITS-1];
        end
    end

    // Word stays put until the next full frame, far beyond the sync latency
    always_ff @(posedge serialClk or negedge rst_n) begin
        if (!rst_n) begin
            frameWord_q <= '0;
            frameTgl_q <= 1'b0;
        end else if (!selRawN && bitCnt_q == FRAME_LAST) begin
            frameWord_q <= {shift_q[FRAME_BITS-2:0], serialIn};
            frameTgl_q <= ~frameTgl_q;
        end
    end

    assign serialOut = serialOut_q;

    logic tglS1_q;
    logic tglS2_q;
    logic tglS3_q;
    logic serialEvt;
    logic serWr;
    logic [3:0] serIdx;
    logic [15:0] serData;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tglS1_q <= 1'b0;
            tglS2_q <= 1'b0;
            tglS3_q <= 1'b0;
        end else begin
            tglS1_q <= frameTgl_q;
            tglS2_q <= tglS1_q;
            tglS3_q <= tglS2_q;
        end
    end

    assign serialEvt = tglS2_q ^ tglS3_q;
    assign serWr = serialEvt & ~frameWord_q[FRAME_RD_BIT];
    assign serIdx = frameWord_q[FRAME_IDX_LSB+3:FRAME_IDX_LSB];
    assign serData = frameWord_q[15:0];

    // AXI4-Lite write channel
    logic awHeld_q;
    logic awHeld_d;
    logic wHeld_q;
    logic wHeld_d;
    logic bvalid_d;
    logic doWrite;
    logic [7:0] awAddr_q;
    logic [15:0] wData_q;
    logic [1:0] wStrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wrMapped;

    always_comb begin
        doWrite = awHeld_q & wHeld_q & ~bvalid_q;
        awHeld_d = doWrite ? 1'b0 : (awHeld_q | (s_axi_awvalid & awready_q));
        wHeld_d = doWrite ? 1'b0 : (wHeld_q | (s_axi_wvalid & wready_q));
        bvalid_d = doWrite | (bvalid_q & ~s_axi_bready);
    end

    assign wrMapped = isIdx(awAddr_q, IDX_CTRL) | isIdx(awAddr_q, IDX_STATUS)
                    | isIdx(awAddr_q, IDX_SPAN_I) | isIdx(awAddr_q, IDX_SPAN_Q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bresp_q <= RESP_OKAY;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            bvalid_q <= bvalid_d;
            awready_q <= ~awHeld_d & ~bvalid_d;
            wready_q <= ~wHeld_d & ~bvalid_d;
            if (s_axi_awvalid && awready_q) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wData_q <= s_axi_wdata[15:0];
                wStrb_q <= s_axi_wstrb[1:0];
            end
            if (doWrite) begin
                bresp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Control registers; AXI wins over a serial write in the same cycle
    logic [15:0] ctrl_q;
    logic [15:0] spanI_q;
    logic [15:0] spanQ_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            spanI_q <= SPAN_RESET;
            spanQ_q <= SPAN_RESET;
        end else if (!extended_control_mode) begin
            ctrl_q <= CTRL_RESET;
            spanI_q <= SPAN_RESET;
            spanQ_q <= SPAN_RESET;
        end else begin
            if (serWr) begin
                if (serIdx == IDX_CTRL) begin
                    ctrl_q <= serData;
                end
                if (serIdx == IDX_SPAN_I) begin
                    spanI_q <= serData;
                end
                if (serIdx == IDX_SPAN_Q) begin
                    spanQ_q <= serData;
                end
            end
            if (doWrite) begin
                if (isIdx(awAddr_q, IDX_CTRL)) begin
                    ctrl_q <= mergeBytes(ctrl_q, wData_q, wStrb_q);
                end
                if (isIdx(awAddr_q, IDX_SPAN_I)) begin
                    spanI_q <= mergeBytes(spanI_q, wData_q, wStrb_q);
                end
                if (isIdx(awAddr_q, IDX_SPAN_Q)) begin
                    spanQ_q <= mergeBytes(spanQ_q, wData_q, wStrb_q);
                end
            end
        end
    end

    // Trim sequencer
    cpms_trim_state_t state_q;
    cpms_trim_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] waitLast;
    logic armed_q;
    logic inhibit_q;
    logic trimReq;
    logic cmdStart;

    assign trimReq = pinF.trimRequest | (extended_control_mode & ctrl_q[CTRL_TRIM_BIT]);
    assign cmdStart = armed_q & trimReq & (state_q == ST_IDLE || state_q == ST_WAIT);
    assign waitLast = pinF.trimDelaySelect ? CNT_W'(TRIM_LONG_CYCLES - 1)
                                           : CNT_W'(TRIM_SHORT_CYC - 1);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_SETTLE: begin
                if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cmdStart) begin
                    state_d = ST_RUN;
                end else if (cnt_q >= waitLast) begin
                    state_d = inhibit_q ? ST_IDLE : ST_RUN;
                end
            end
            ST_IDLE: begin
                if (cmdStart) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cnt_q == CNT_W'(TRIM_RUN_CYCLES - 1)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SETTLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);
        end
    end

    // Arming needs a low request after settle; the synchroniser shows idle pins before
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (!trimReq && state_q != ST_SETTLE) begin
            armed_q <= 1'b1;
        end else if (cmdStart) begin
            armed_q <= 1'b0;
        end
    end

    // Strap caught once the synchroniser has settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_q <= 1'b0;
        end else if (state_q == ST_SETTLE && state_d == ST_WAIT) begin
            inhibit_q <= pinF.trimRequest;
        end else if (cmdStart) begin
            inhibit_q <= 1'b0;
        end
    end

    logic running_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running_q <= 1'b0;
        end else begin
            running_q <= (state_d == ST_RUN);
        end
    end

    assign selfTrimRunning = running_q;

    // Effective settings
    cpms_setting_t settings_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settings_q <= '0;
        end else begin
            settings_q.extendedControlMode <= extended_control_mode;
            settings_q.powerDownI <= pinF.powerDownI | (extended_control_mode & ctrl_q[CTRL_PDI_BIT]);
            settings_q.powerDownQ <= pinF.powerDownQ | (extended_control_mode & ctrl_q[CTRL_PDQ_BIT]);
            settings_q.testPatternOn <= extended_control_mode ? ctrl_q[CTRL_TEST_BIT]
                                            : pinF.testPatternSelect;
            settings_q.unsplitOutput <= pinF.unsplitOutputSelect;
            settings_q.spanI <= extended_control_mode ? spanI_q : (pinF.inputSpanSelect ? SPAN_HIGH_CODE
                                                                      : SPAN_LOW_CODE);
            settings_q.spanQ <= extended_control_mode ? spanQ_q : (pinF.inputSpanSelect ? SPAN_HIGH_CODE
                                                                      : SPAN_LOW_CODE);
            // Phase is meaningless in 1:1 mode, so it is forced to 0 degrees there
            settings_q.outputPhase90 <= ~pinF.unsplitOutputSelect
                                        & (extended_control_mode ? ctrl_q[CTRL_PHASE_BIT]
                                               : pinF.outputPhaseSelect);
        end
    end

    assign settings = settings_q;

    logic serialOutEn_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialOutEn_q <= 1'b0;
        end else begin
            serialOutEn_q <= extended_control_mode & ~pinF.serialSelectN;
        end
    end

    assign serialOutEn = serialOutEn_q;

    // AXI4-Lite read channel
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [15:0] rdMux;
    logic rdMapped;
    logic [15:0] statusWord;

    always_comb begin
        statusWord = '0;
        statusWord[STAT_RUN_BIT] = running_q;
        statusWord[STAT_ECM_BIT] = extended_control_mode;
        statusWord[STAT_INHIBIT_BIT] = inhibit_q;
        rdMapped = 1'b1;
        rdMux = '0;
        if (isIdx(s_axi_araddr, IDX_CTRL)) begin
            rdMux = ctrl_q;
        end else if (isIdx(s_axi_araddr, IDX_STATUS)) begin
            rdMux = statusWord;
        end else if (isIdx(s_axi_araddr, IDX_SPAN_I)) begin
            rdMux = spanI_q;
        end else if (isIdx(s_axi_araddr, IDX_SPAN_Q)) begin
            rdMux = spanQ_q;
        end else begin
            rdMapped = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rdMux};
            rresp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : cpms_top
`default_nettype wire

// File: cpms_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cpms_sva
    import cpms_pkg::*;
#(
    parameter int unsigned TRIM_RUN_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire cpms_pkg::cpms_pins_t ctrlPins,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic selfTrimRunning,
    input wire cpms_pkg::cpms_setting_t settings,
    input wire logic serialOutEn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    cpms_pins_t p;
    cpms_setting_t s;
    logic [15:0] runCnt_q;
    assign p = ctrlPins;
    assign s = settings;
    // Counts high cycles of the current run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runCnt_q <= 16'h0000;
        end else begin
            runCnt_q <= selfTrimRunning ? runCnt_q + 16'h0001 : 16'h0000;
        end
    end
    run_len_a: assert property ($fell(selfTrimRunning) |-> runCnt_q == 16'(TRIM_RUN_CYCLES))
        else $error("trim run length wrong");
    run_max_a: assert property (selfTrimRunning |-> runCnt_q < 16'(TRIM_RUN_CYCLES))
        else $error("trim run too long");
    pd_i_a: assert property (p.powerDownI [*8] |-> s.powerDownI)
        else $error("channel I not powered down");
    pd_q_a: assert property (p.powerDownQ [*8] |-> s.powerDownQ)
        else $error("channel Q not powered down");
    unsplit_a: assert property ($stable(p.unsplitOutputSelect) [*8]
        |-> s.unsplitOutput == p.unsplitOutputSelect)
        else $error("output split mode wrong");
    phase_split_a: assert property (s.unsplitOutput |-> !s.outputPhase90)
        else $error("phase set in unsplit mode");
    span_pin_a: assert property ((p.extendedControlEnableN && $stable(p.inputSpanSelect)) [*8]
        |-> s.spanI == (p.inputSpanSelect ? SPAN_HIGH_CODE : SPAN_LOW_CODE)
        && s.spanQ == s.spanI)
        else $error("span not from pin");
    test_pin_a: assert property ((p.extendedControlEnableN && $stable(p.testPatternSelect)) [*8]
        |-> s.testPatternOn == p.testPatternSelect)
        else $error("test pattern not from pin");
    ecm_flag_a: assert property ($stable(p.extendedControlEnableN) [*8]
        |-> s.extendedControlMode == !p.extendedControlEnableN)
        else $error("extended mode flag wrong");
    serial_en_a: assert property (($stable(p.extendedControlEnableN) && $stable(p.serialSelectN)) [*8]
        |-> serialOutEn == (!p.extendedControlEnableN && !p.serialSelectN))
        else $error("serial output enable wrong");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    cover property ($rose(selfTrimRunning));
    cover property ($rose(s.extendedControlMode));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : cpms_sva
`default_nettype wire

// File: cpms_serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module cpms_serial_host (
    output var logic serialClk,
    output var logic serialIn,
    output var logic serialSelectN
);
    initial begin
        serialClk = 1'b0;
        serialIn = 1'b0;
        serialSelectN = 1'b1;
    end
    // Clock idles low outside frames, so no stray edge reaches the shifter
    task automatic send_frame(input logic [23:0] f);
        int i;
        // Gap of over four clocks lets the previous word cross
        #173 serialSelectN = 1'b0;
        for (i = 23; i >= 0; i--) begin
            serialIn = f[i];
            #24 serialClk = 1'b1;
            #24 serialClk = 1'b0;
        end
        serialSelectN = 1'b1;
        // Released line shows no stale bit
        serialIn = ~f[0];
    endtask : send_frame
endmodule : cpms_serial_host
`default_nettype wire

// File: control_pin_mode_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module control_pin_mode_select_tb;
    import cpms_pkg::*;
    localparam int RUN = 20;
    localparam int LONGW = 40;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, serial_in, selN, serialOut, serialOutEn, selfTrimRunning;
    cpms_pins_t pins = PINS_IDLE;
    cpms_pins_t pinsAll;
    cpms_setting_t settings, e;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [33:0] rdQ[$];
    logic [1:0] wrQ[$];
    logic [15:0] v;
    logic [5:0] r;
    int err_count = 0;
    int tests_run = 0;

    always #20 clk = ~clk;
    always_comb begin
        pinsAll = pins;
        pinsAll.serialSelectN = selN;
    end

    cpms_top #(.TRIM_LONG_CYCLES(LONGW), .TRIM_RUN_CYCLES(RUN)) dut (
        .clk, .rst_n, .serialClk(sclk), .serialIn(serial_in), .ctrlPins(pinsAll),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .selfTrimRunning, .settings, .serialOut, .serialOutEn
    );
    cpms_serial_host host (.serialClk(sclk), .serialIn(serial_in), .serialSelectN(selN));

    task automatic final_report;
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic hang;
        err_count++;
        final_report();
    endtask : hang

    task automatic chk_bus(input logic [33:0] x, input logic [33:0] g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("BAD %0t exp %0h got %0h", $time, x, g);
        end
    endtask : chk_bus

    task automatic chk_set(input cpms_setting_t x, input cpms_setting_t g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("BAD %0t exp %0h got %0h", $time, x, g);
        end
    endtask : chk_set

    task automatic chk_bit(input logic x, input logic g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("BAD %0t exp %0h got %0h", $time, x, g);
        end
    endtask : chk_bit

    // Bus results are matched in order of issue
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            chk_bus(rdQ.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (s_axi_bvalid && s_axi_bready) begin
            chk_bus({wrQ.pop_front(), 32'h0}, {s_axi_bresp, 32'h0});
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
        int n;
        wrQ.push_back(x);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n >= 40) hang();
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        int n;
        rdQ.push_back(x);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n >= 40) hang();
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic do_reset(input logic td, input logic tr);
        @(posedge clk);
        rst_n <= 1'b0;
        pins <= {td, tr, 8'h03};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // Start of a run must land inside lo..hi edges; exp low means none inside that window
    task automatic wait_run(input int lo, input int hi, input logic exp);
        int n;
        int m;
        for (n = 0; n <= hi && !selfTrimRunning; n++) @(posedge clk);
        chk_bit(exp, n >= lo && n <= hi);
        for (m = 0; m < 200 && selfTrimRunning; m++) @(posedge clk);
        if (exp) chk_bit(1'b1, m == RUN);
    endtask : wait_run

    initial begin
        r = 6'($urandom(32'h511C339F));
        do_reset(1'b1, 1'b1);
        wait_run(0, 200, 1'b0);
        pins.trimRequest <= 1'b0;
        repeat (6) @(posedge clk);
        pins.trimRequest <= 1'b1;
        wait_run(0, 10, 1'b1);
        do_reset(1'b1, 1'b0);
        wait_run(LONGW, LONGW + 20, 1'b1);
        do_reset(1'b0, 1'b0);
        wait_run(TRIM_SHORT_CYC, TRIM_SHORT_CYC + 20, 1'b1);
        repeat (8) begin
            r = 6'($urandom);
            e = '0;
            e.powerDownI = r[0];
            e.powerDownQ = r[1];
            e.testPatternOn = r[2];
            e.unsplitOutput = r[3];
            e.outputPhase90 = r[5] & ~r[3];
            e.spanI = r[4] ? SPAN_HIGH_CODE : SPAN_LOW_CODE;
            e.spanQ = e.spanI;
            @(posedge clk);
            pins <= {2'b00, r[0], r[1], r[2], r[3], r[4], r[5], 2'b11};
            repeat (10) @(posedge clk);
            chk_set(e, settings);
        end
        @(posedge clk);
        pins <= {2'b00, 8'h40};
        repeat (10) @(posedge clk);
        v = 16'($urandom);
        wr(8'h00, 32'h5800, RESP_OKAY);
        wr(8'h0C, {16'h0, v}, RESP_OKAY);
        wr(8'h2C, 32'hABCD, RESP_OKAY);
        wr(8'h3C, 32'h1, RESP_SLVERR);
        repeat (8) @(posedge clk);
        e = {6'b111011, v, 16'hABCD};
        chk_set(e, settings);
        rd(8'h00, {RESP_OKAY, 32'h5800});
        rd(8'h3C, {RESP_SLVERR, 32'h0});
        rd(8'h04, {RESP_OKAY, 32'h2});
        wr(8'h00, 32'hD800, RESP_OKAY);
        wait_run(0, 12, 1'b1);
        wr(8'h00, 32'h5800, RESP_OKAY);
        host.send_frame({8'h03, 16'h0F0F});
        host.send_frame({8'h8B, 16'h1234});
        repeat (8) @(posedge clk);
        chk_bit(1'b0, serialOutEn);
        chk_bit(1'b0, serialOut);
        rd(8'h0C, {RESP_OKAY, 32'h0F0F});
        rd(8'h2C, {RESP_OKAY, 32'hABCD});
        @(posedge clk);
        pins.extendedControlEnableN <= 1'b1;
        repeat (10) @(posedge clk);
        wr(8'h0C, 32'h1111, RESP_OKAY);
        host.send_frame({8'h03, 16'h2222});
        repeat (8) @(posedge clk);
        rd(8'h0C, {RESP_OKAY, 16'h0, SPAN_RESET});
        rd(8'h00, {RESP_OKAY, 32'h0});
        e = {6'b010000, SPAN_LOW_CODE, SPAN_LOW_CODE};
        chk_set(e, settings);
        final_report();
    end
endmodule : control_pin_mode_select_tb

bind cpms_top cpms_sva #(.TRIM_RUN_CYCLES(TRIM_RUN_CYCLES)) chk (
    .clk, .rst_n, .ctrlPins, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
    .s_axi_rvalid, .selfTrimRunning, .settings, .serialOutEn
);
`default_nettype wire
